// file: core/bdu_consts.svh
// constants of the decimal add, decrement and divide unit
`ifndef BDU_CONSTS_SVH
`define BDU_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BDU_ADR_W 8
`define BDU_OFS_CTRL 8'h00
`define BDU_OFS_STATUS 8'h04
`define BDU_OFS_FLAGS 8'h08
`define BDU_OFS_ACC_LOWER 8'h0C
`define BDU_OFS_ACC_UPPER 8'h10
`define BDU_OFS_ADDR_FIRST 8'h14
`define BDU_OFS_ADDR_SECOND 8'h18
`define BDU_OFS_MEM_OPND 8'h1C
`define BDU_OFS_IMM_SRC 8'h20
`define BDU_OFS_IRQ_STAT 8'h24
`define BDU_OFS_IRQ_MASK 8'h28

// ----------------------------------------
// field positions
// ----------------------------------------
`define BDU_CTRL_OP_LSB 0
`define BDU_CTRL_WORD_BIT 3
`define BDU_CTRL_DST_LSB 4
`define BDU_CTRL_SRC_LSB 8
`define BDU_CTRL_W 12
`define BDU_FLAG_S 0
`define BDU_FLAG_Z 1
`define BDU_FLAG_C 2
`define BDU_FLAG_O 3
`define BDU_FLAG_W 4
`define BDU_EV_DONE 0
`define BDU_EV_OVF 1
`define BDU_EV_REJ 2
`define BDU_EV_W 3

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define BDU_RST_WORD 16'h0000
`define BDU_RST_FLAGS 4'h0
`define BDU_RST_MASK 3'h0
`define BDU_DIV_STEPS 6'h20

`endif

// file: core/bdu_pkg.sv
// types of the decimal add, decrement and divide unit
package bdu_pkg;

	// ----------------------------------------
	// commands and operand selectors
	// ----------------------------------------
	typedef enum logic [2:0] {
		bcd_add_carry_op,
		bcd_add_plain_op,
		minus_one_op,
		signed_quotient_op,
		unsigned_quotient_op
	} bdu_op_t;

	typedef enum logic [2:0] {
		sel_acc_lo,
		sel_acc_hi,
		sel_addr_first,
		sel_addr_second,
		sel_mem_static,
		sel_mem_frame,
		sel_mem_abs,
		sel_imm
	} bdu_sel_t;

	typedef enum logic [1:0] {
		div_idle,
		div_run,
		div_fin
	} bdu_div_state_t;

	// ----------------------------------------
	// state records
	// ----------------------------------------
	typedef struct packed {
		bdu_div_state_t st;
		logic [5:0] cnt;
		logic [16:0] rem;
		logic [31:0] quo;
		logic [15:0] dv;
		logic neg_q;
		logic neg_r;
		logic sgn;
		logic word;
		logic done;
		logic ovf;
		logic [15:0] q_out;
		logic [15:0] r_out;
	} bdu_div_t;

	typedef struct packed {
		logic [15:0] acc_lower;
		logic [15:0] acc_upper;
		logic [15:0] addr_first;
		logic [15:0] addr_second;
		logic [15:0] mem_opnd;
		logic [15:0] imm_src;
		logic [11:0] ctrl;
		logic [3:0] flags;
		logic busy;
		logic div_word;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic ack;
		logic [31:0] dat;
		logic irq;
		logic div_start;
		logic div_sgn;
		logic [31:0] div_dd;
		logic [15:0] div_dv;
	} bdu_core_t;

endpackage : bdu_pkg

// file: core/bdu_div_if.sv
// link between the unit and its divider
`timescale 1ns/10ps
interface bdu_div_if;
	logic start;
	logic signed_mode;
	logic word;
	logic [31:0] dividend;
	logic [15:0] divisor;
	logic done;
	logic ovf;
	logic [15:0] quotient;
	logic [15:0] remainder;

	modport requester (output start, signed_mode, word, dividend, divisor,
		input done, ovf, quotient, remainder);
	modport divider (input start, signed_mode, word, dividend, divisor,
		output done, ovf, quotient, remainder);
endinterface : bdu_div_if

// file: core/bdu_divider.sv
// iterative divider, one quotient bit per clock
`timescale 1ns/10ps
`include "bdu_consts.svh"
module bdu_divider import bdu_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// request and answer
	bdu_div_if.divider dif
);

	bdu_div_t cur;
	bdu_div_t nx;
	logic [31:0] dd_mag;
	logic [16:0] trial;
	logic fits;
	logic [31:0] lim;

	always_comb begin
		nx = cur;
		nx.done = 1'b0;
		dd_mag = '0;
		trial = '0;
		fits = 1'b0;
		lim = '0;
		unique case (cur.st)
			div_idle: begin
				if (dif.start) begin
					// work on magnitudes, fix signs at the end
					dd_mag = (dif.signed_mode & dif.dividend[31]) ? 32'(-dif.dividend) : dif.dividend;
					nx.dv = (dif.signed_mode & dif.divisor[15]) ? 16'(-dif.divisor) : dif.divisor;
					nx.neg_q = dif.signed_mode & (dif.dividend[31] ^ dif.divisor[15]);
					nx.neg_r = dif.signed_mode & dif.dividend[31];
					nx.sgn = dif.signed_mode;
					nx.word = dif.word;
					nx.quo = dd_mag;
					nx.rem = '0;
					nx.cnt = '0;
					if (dif.divisor == 16'h0000) begin
						nx.done = 1'b1;
						nx.ovf = 1'b1;
					end else begin
						nx.st = div_run;
					end
				end
			end
			div_run: begin
				trial = {cur.rem[15:0], cur.quo[31]};
				if (trial >= {1'b0, cur.dv}) begin
					nx.rem = 17'(trial - {1'b0, cur.dv});
					nx.quo = {cur.quo[30:0], 1'b1};
				end else begin
					nx.rem = trial;
					nx.quo = {cur.quo[30:0], 1'b0};
				end
				nx.cnt = 6'(cur.cnt + 6'h01);
				if (nx.cnt == `BDU_DIV_STEPS)
					nx.st = div_fin;
			end
			div_fin: begin
				if (cur.sgn)
					lim = cur.word ? (cur.neg_q ? 32'h0000_8000 : 32'h0000_7FFF)
						: (cur.neg_q ? 32'h0000_0080 : 32'h0000_007F);
				else
					lim = cur.word ? 32'h0000_FFFF : 32'h0000_00FF;
				fits = cur.quo <= lim;
				nx.ovf = ~fits;
				nx.q_out = cur.neg_q ? 16'(-cur.quo[15:0]) : cur.quo[15:0];
				nx.r_out = cur.neg_r ? 16'(-cur.rem[15:0]) : cur.rem[15:0];
				nx.done = 1'b1;
				nx.st = div_idle;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			cur <= '{st: div_idle, default: '0};
		else
			cur <= nx;
	end

	assign dif.done = cur.done;
	assign dif.ovf = cur.ovf;
	assign dif.quotient = cur.q_out;
	assign dif.remainder = cur.r_out;

endmodule : bdu_divider

// file: core/bdu_unit.sv
// decimal add, decrement and divide unit with wishbone register access
`timescale 1ns/10ps
`include "bdu_consts.svh"
module bdu_unit import bdu_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// wishbone slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [`BDU_ADR_W-1:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	// interrupt
	output logic irq
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : wr16

	// packed bcd sum; bit 16 is the decimal carry out of the selected size
	function automatic logic [16:0] bcd_add(input logic [15:0] a, input logic [15:0] b, input logic cin,
		input logic word);
		logic [4:0] d;
		logic c;
		logic c_byte;
		logic [15:0] r;
		c = cin;
		c_byte = 1'b0;
		r = '0;
		for (int i = 0; i < 4; i++) begin
			d = 5'({1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c});
			if (d > 5'h09) begin
				d = 5'(d + 5'h06);
				c = 1'b1;
			end else begin
				c = 1'b0;
			end
			r[i*4 +: 4] = d[3:0];
			if (i == 1)
				c_byte = c;
		end
		return word ? {c, r} : {c_byte, 8'h00, r[7:0]};
	endfunction : bcd_add

	// byte views read the low eight bits (sel_acc_hi gives the high byte of acc_lower), so address registers give their low byte
	function automatic logic [15:0] get_opnd(input bdu_core_t s, input bdu_sel_t sel, input logic word);
		logic [15:0] v;
		v = '0;
		unique case (sel)
			sel_acc_lo: v = s.acc_lower;
			sel_acc_hi: v = word ? s.acc_upper : {8'h00, s.acc_lower[15:8]};
			sel_addr_first: v = s.addr_first;
			sel_addr_second: v = s.addr_second;
			sel_mem_static, sel_mem_frame, sel_mem_abs: v = s.mem_opnd;
			sel_imm: v = s.imm_src;
		endcase
		return word ? v : {8'h00, v[7:0]};
	endfunction : get_opnd

	function automatic bdu_core_t put_opnd(input bdu_core_t s, input bdu_sel_t sel, input logic word,
		input logic [15:0] v);
		bdu_core_t t;
		t = s;
		unique case (sel)
			sel_acc_lo: if (word) t.acc_lower = v; else t.acc_lower[7:0] = v[7:0];
			sel_acc_hi: if (word) t.acc_upper = v; else t.acc_lower[15:8] = v[7:0];
			sel_addr_first: if (word) t.addr_first = v; else t.addr_first[7:0] = v[7:0];
			sel_addr_second: if (word) t.addr_second = v; else t.addr_second[7:0] = v[7:0];
			sel_mem_static, sel_mem_frame, sel_mem_abs: if (word) t.mem_opnd = v; else t.mem_opnd[7:0] = v[7:0];
			sel_imm: t = s;
		endcase
		return t;
	endfunction : put_opnd

	// ----------------------------------------
	// state
	// ----------------------------------------
	bdu_core_t cur;
	bdu_core_t nx;
	bdu_div_if dif ();

	logic take;
	logic go;
	logic [7:0] word_adr;
	logic [31:0] rd_val;
	logic [2:0] ev;
	logic [2:0] clr;
	bdu_op_t op;
	bdu_sel_t dst;
	bdu_sel_t src;
	logic word;
	logic [15:0] a_val;
	logic [15:0] b_val;
	logic [16:0] sum;
	logic [15:0] res;
	logic msb;
	logic legal;

	bdu_divider u_div (
		.clock(clock),
		.rst_b(rst_b),
		.dif(dif)
	);

	assign dif.start = cur.div_start;
	assign dif.signed_mode = cur.div_sgn;
	assign dif.word = cur.div_word;
	assign dif.dividend = cur.div_dd;
	assign dif.divisor = cur.div_dv;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nx = cur;
		nx.div_start = 1'b0;
		ev = '0;
		clr = '0;
		rd_val = '0;
		sum = '0;
		res = '0;
		msb = 1'b0;
		legal = 1'b0;
		a_val = '0;
		b_val = '0;
		take = wb_cyc & wb_stb & ~cur.ack;
		word_adr = {wb_adr[7:2], 2'b00};
		go = take & wb_we & (word_adr == `BDU_OFS_CTRL);
		op = bdu_op_t'(wb_dat_w[`BDU_CTRL_OP_LSB +: 3]);
		dst = bdu_sel_t'(wb_dat_w[`BDU_CTRL_DST_LSB +: 3]);
		src = bdu_sel_t'(wb_dat_w[`BDU_CTRL_SRC_LSB +: 3]);
		word = wb_dat_w[`BDU_CTRL_WORD_BIT];
		nx.ack = take;

		unique case (word_adr)
			`BDU_OFS_CTRL: rd_val = {20'h00000, cur.ctrl};
			`BDU_OFS_STATUS: rd_val = {31'h00000000, cur.busy};
			`BDU_OFS_FLAGS: rd_val = {28'h0000000, cur.flags};
			`BDU_OFS_ACC_LOWER: rd_val = {16'h0000, cur.acc_lower};
			`BDU_OFS_ACC_UPPER: rd_val = {16'h0000, cur.acc_upper};
			`BDU_OFS_ADDR_FIRST: rd_val = {16'h0000, cur.addr_first};
			`BDU_OFS_ADDR_SECOND: rd_val = {16'h0000, cur.addr_second};
			`BDU_OFS_MEM_OPND: rd_val = {16'h0000, cur.mem_opnd};
			`BDU_OFS_IMM_SRC: rd_val = {16'h0000, cur.imm_src};
			`BDU_OFS_IRQ_STAT: rd_val = {29'h00000000, cur.irq_stat};
			`BDU_OFS_IRQ_MASK: rd_val = {29'h00000000, cur.irq_mask};
			default: rd_val = '0;
		endcase
		if (take & ~wb_we)
			nx.dat = rd_val;

		if (take & wb_we) begin
			unique case (word_adr)
				`BDU_OFS_FLAGS: if (wb_sel[0]) nx.flags = wb_dat_w[`BDU_FLAG_W-1:0];
				`BDU_OFS_ACC_LOWER: nx.acc_lower = wr16(cur.acc_lower, wb_dat_w, wb_sel);
				`BDU_OFS_ACC_UPPER: nx.acc_upper = wr16(cur.acc_upper, wb_dat_w, wb_sel);
				`BDU_OFS_ADDR_FIRST: nx.addr_first = wr16(cur.addr_first, wb_dat_w, wb_sel);
				`BDU_OFS_ADDR_SECOND: nx.addr_second = wr16(cur.addr_second, wb_dat_w, wb_sel);
				`BDU_OFS_MEM_OPND: nx.mem_opnd = wr16(cur.mem_opnd, wb_dat_w, wb_sel);
				`BDU_OFS_IMM_SRC: nx.imm_src = wr16(cur.imm_src, wb_dat_w, wb_sel);
				`BDU_OFS_IRQ_STAT: if (wb_sel[0]) clr = wb_dat_w[`BDU_EV_W-1:0];
				`BDU_OFS_IRQ_MASK: if (wb_sel[0]) nx.irq_mask = wb_dat_w[`BDU_EV_W-1:0];
				default: nx.flags = nx.flags;
			endcase
		end

		// ----------------------------------------
		// command launch
		// ----------------------------------------
		if (go) begin
			a_val = get_opnd(cur, dst, word);
			b_val = get_opnd(cur, src, word);
			msb = 1'b0;
			if (cur.busy) begin
				// a divide in flight owns the accumulator, so the command is dropped
				ev[`BDU_EV_REJ] = 1'b1;
			end else begin
				nx.ctrl = wb_dat_w[`BDU_CTRL_W-1:0];
				unique case (op)
					bcd_add_carry_op, bcd_add_plain_op: begin
						if (dst == sel_imm) begin
							ev[`BDU_EV_REJ] = 1'b1;
						end else begin
							sum = bcd_add(a_val, b_val, (op == bcd_add_carry_op) & cur.flags[`BDU_FLAG_C],
								word);
							res = sum[15:0];
							nx = put_opnd(nx, dst, word, res);
							msb = word ? res[15] : res[7];
							nx.flags[`BDU_FLAG_C] = sum[16];
							nx.flags[`BDU_FLAG_S] = msb;
							nx.flags[`BDU_FLAG_Z] = res == 16'h0000;
							ev[`BDU_EV_DONE] = 1'b1;
						end
					end
					minus_one_op: begin
						legal = word ? (dst == sel_addr_first || dst == sel_addr_second)
							: (dst == sel_acc_lo || dst == sel_acc_hi || dst == sel_mem_static
							|| dst == sel_mem_frame || dst == sel_mem_abs);
						if (!legal) begin
							ev[`BDU_EV_REJ] = 1'b1;
						end else begin
							res = word ? 16'(a_val - 16'h0001) : {8'h00, 8'(a_val[7:0] - 8'h01)};
							nx = put_opnd(nx, dst, word, res);
							msb = word ? res[15] : res[7];
							nx.flags[`BDU_FLAG_S] = msb;
							nx.flags[`BDU_FLAG_Z] = res == 16'h0000;
							ev[`BDU_EV_DONE] = 1'b1;
						end
					end
					signed_quotient_op, unsigned_quotient_op: begin
						nx.busy = 1'b1;
						nx.div_start = 1'b1;
						nx.div_word = word;
						nx.div_sgn = op == signed_quotient_op;
						if (word) begin
							nx.div_dd = {cur.acc_upper, cur.acc_lower};
							nx.div_dv = b_val;
						end else begin
							nx.div_dd = {(op == signed_quotient_op) ? {16{cur.acc_lower[15]}} : 16'h0000,
								cur.acc_lower};
							nx.div_dv = {(op == signed_quotient_op) ? {8{b_val[7]}} : 8'h00,
								b_val[7:0]};
						end
					end
					default: ev[`BDU_EV_REJ] = 1'b1;
				endcase
			end
		end

		// ----------------------------------------
		// divide completion
		// ----------------------------------------
		if (dif.done) begin
			nx.busy = 1'b0;
			ev[`BDU_EV_DONE] = 1'b1;
			// only overflow moves; other flags keep their value
			nx.flags[`BDU_FLAG_O] = dif.ovf;
			if (dif.ovf) begin
				// accumulator left as it was, which is one legal undefined outcome
				ev[`BDU_EV_OVF] = 1'b1;
			end else if (cur.div_word) begin
				nx.acc_lower = dif.quotient;
				nx.acc_upper = dif.remainder;
			end else begin
				nx.acc_lower = {dif.remainder[7:0], dif.quotient[7:0]};
			end
		end

		// set wins over a clear in the same cycle
		nx.irq_stat = (cur.irq_stat & ~clr) | ev;
		nx.irq = |(nx.irq_stat & nx.irq_mask);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			cur <= '{flags: `BDU_RST_FLAGS, irq_mask: `BDU_RST_MASK, default: '0};
		else
			cur <= nx;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_dat_r = cur.dat;
	assign wb_ack = cur.ack;
	assign irq = cur.irq;

endmodule : bdu_unit

// file: testbench/bdu_unit_chk.sv
// checker of the unit's bus and interrupt ports
`timescale 1ns/10ps
`include "bdu_consts.svh"
module bdu_unit_chk (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// wishbone slave side
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [`BDU_ADR_W-1:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	input wire logic [31:0] wb_dat_r,
	input wire logic wb_ack,
	// interrupt
	input wire logic irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	logic take;
	logic rd_ack;
	assign take = wb_cyc && wb_stb && !wb_ack;
	assign rd_ack = wb_ack && !wb_we;

	// ----------------------------------------
	// handshake
	// ----------------------------------------
	a_ack_one_cycle: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
	a_ack_after_take: assert property (take |=> wb_ack) else $error("request not acked next cycle");
	a_ack_needs_req: assert property (wb_ack |-> $past(wb_cyc && wb_stb)) else $error("ack without request");
	a_quiet_after_reset: assert property ($rose(rst_b) |-> !wb_ack && !irq) else $error("outputs busy after reset");

	// ----------------------------------------
	// read data and interrupt
	// ----------------------------------------
	a_unmapped_reads_zero: assert property (rd_ack && wb_adr > 8'h2B |-> wb_dat_r == 32'h0)
		else $error("unmapped read not zero");
	a_flags_read_width: assert property (rd_ack && wb_adr[7:2] == 6'h02 |-> wb_dat_r[31:4] == 28'h0)
		else $error("flag read upper bits set");
	a_status_read_width: assert property (rd_ack && wb_adr[7:2] == 6'h01 |-> wb_dat_r[31:1] == 31'h0)
		else $error("status read upper bits set");
	a_mask_gates_irq: assert property (take && wb_we && wb_adr[7:2] == 6'h0A && wb_sel[0] && wb_dat_w[2:0] == 3'h0
		|=> !irq [*3]) else $error("irq high with mask cleared");
endmodule : bdu_unit_chk

bind bdu_unit bdu_unit_chk chk_u (.clock(clock), .rst_b(rst_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
	.wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .irq(irq));

// file: testbench/tb_top.sv
// self-checking bench of the decimal add, decrement and divide unit
`timescale 1ns/10ps
`include "bdu_consts.svh"
module tb_top import bdu_pkg::*;;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic irq;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	logic [31:0] seed = 32'h1E;
	logic [31:0] q;
	logic [31:0] dd;
	logic [32:0] rf;
	logic [16:0] s;
	logic [15:0] a;
	logic [15:0] b;
	logic [15:0] e;
	logic [15:0] v;
	logic [7:0] off;
	logic [3:0] fl;
	logic [2:0] d;
	logic w;
	logic sg;
	logic bad;
	bdu_op_t op;

	always #10 clock = ~clock;

	bdu_unit dut_u (.clock(clock), .rst_b(rst_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .irq(irq));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task close_out;
		$display("checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	always @(posedge clock) begin
		cycles++;
		if (cycles == 12000) begin
			err_count++;
			$display("MISMATCH run length expected done seen hang");
			close_out();
		end
	end

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// one classic cycle; request held until ack is sampled
	task xfer(input logic we, input logic [7:0] ad, input logic [31:0] dw);
		int k;
		k = 0;
		@(posedge clock);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= ad;
		wb_sel <= 4'hF;
		wb_dat_w <= dw;
		do begin
			@(posedge clock);
			k++;
		end while (wb_ack !== 1'b1 && k < 16);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		check("ack", 32'h1, {31'h0, wb_ack});
	endtask : xfer

	task cmd(input bdu_op_t o, input logic wd, input logic [2:0] ds, input logic [2:0] sr);
		xfer(1'b1, `BDU_OFS_CTRL, {21'h0, sr, 1'b0, ds, wd, o});
	endtask : cmd

	task irq_is(input logic exp);
		@(posedge clock);
		#1;
		check("irq", {31'h0, exp}, {31'h0, irq});
	endtask : irq_is

	function automatic logic [15:0] bcd_rand();
		logic [15:0] r;
		for (int i = 0; i < 4; i++) r[4*i+:4] = 4'(rnd() % 10);
		return r;
	endfunction : bcd_rand

	function automatic logic [16:0] bcd_sum(input logic [15:0] x, input logic [15:0] y, input logic ci, input logic wd);
		logic [4:0] t;
		logic c;
		logic [15:0] r;
		c = ci;
		r = 16'h0000;
		for (int i = 0; i < (wd ? 4 : 2); i++) begin
			t = {1'b0, x[4*i+:4]} + {1'b0, y[4*i+:4]} + {4'h0, c};
			c = t > 5'h09;
			r[4*i+:4] = c ? t[3:0] + 4'h6 : t[3:0];
		end
		return {c, r};
	endfunction : bcd_sum

	// {overflow, quotient, remainder}
	function automatic logic [32:0] div_ref(input logic sgd, input logic wd, input logic [31:0] x, input logic [15:0] y);
		longint p;
		longint m;
		longint qq;
		longint rr;
		longint lim;
		p = wd ? longint'(x) : longint'(x[15:0]);
		m = wd ? longint'(y) : longint'(y[7:0]);
		if (sgd) begin
			p = wd ? longint'($signed(x)) : longint'($signed(x[15:0]));
			m = wd ? longint'($signed(y)) : longint'($signed(y[7:0]));
		end
		lim = wd ? 65536 : 256;
		if (m == 0) return {1'b1, 32'h0};
		qq = p / m;
		rr = p % m;
		if (sgd) return {qq < -(lim / 2) || qq >= lim / 2, qq[15:0], rr[15:0]};
		return {qq >= lim, qq[15:0], rr[15:0]};
	endfunction : div_ref

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		foreach (dd[i]) if (i < 7) begin
			xfer(1'b0, 8'(i * 4 + (i > 0 ? 4 : 0) + (i == 6 ? 8'h18 : 0)), 32'h0);
			check("reset value", 32'h0, q);
		end
		xfer(1'b1, 8'h3C, 32'hFFFF);
		xfer(1'b0, 8'h3C, 32'h0);
		check("unmapped", 32'h0, q);
		$display("test reset done, mismatches %0d", err_count);
		for (int i = 0; i < 24; i++) begin
			q = rnd();
			w = q[0];
			op = q[1] ? bcd_add_carry_op : bcd_add_plain_op;
			fl = q[7:4];
			a = bcd_rand();
			b = bcd_rand();
			if (i == 0) {w, op, fl, a, b} = {1'b1, bcd_add_carry_op, 4'h4, 16'h9999, 16'h0000};
			if (i == 1) {w, op, fl, a, b} = {1'b0, bcd_add_plain_op, 4'hF, 16'h3799, 16'h5500};
			xfer(1'b1, `BDU_OFS_FLAGS, {28'h0, fl});
			xfer(1'b1, `BDU_OFS_ACC_LOWER, {16'h0, a});
			xfer(1'b1, `BDU_OFS_IMM_SRC, {16'h0, b});
			cmd(op, w, sel_acc_lo, sel_imm);
			s = bcd_sum(a, b, op == bcd_add_carry_op && fl[2], w);
			e = w ? s[15:0] : {a[15:8], s[7:0]};
			xfer(1'b0, `BDU_OFS_ACC_LOWER, 32'h0);
			check("decimal sum", {16'h0, e}, q);
			xfer(1'b0, `BDU_OFS_FLAGS, 32'h0);
			check("decimal flags", {28'h0, fl[3], s[16], w ? e == 0 : e[7:0] == 0, w ? e[15] : e[7]}, q);
		end
		$display("test decimal add done, mismatches %0d", err_count);
		for (int k = 0; k < 14; k++) begin
			d = 3'(k % 7);
			bad = k >= 7;
			w = (d == 3'h2 || d == 3'h3) ^ bad;
			a = 16'(rnd());
			fl = 4'(rnd());
			if (d == 3'h2) a = 16'h0001;
			if (d == 3'h1) a[15:8] = 8'h00;
			off = d < 3'h2 ? `BDU_OFS_ACC_LOWER : d == 3'h2 ? `BDU_OFS_ADDR_FIRST :
				d == 3'h3 ? `BDU_OFS_ADDR_SECOND : `BDU_OFS_MEM_OPND;
			xfer(1'b1, `BDU_OFS_FLAGS, {28'h0, fl});
			xfer(1'b1, off, {16'h0, a});
			xfer(1'b1, `BDU_OFS_IRQ_STAT, 32'h7);
			cmd(minus_one_op, w, d, 3'h0);
			e = w ? a - 16'h1 : d == 3'h1 ? {a[15:8] - 8'h01, a[7:0]} : {a[15:8], a[7:0] - 8'h01};
			e = bad ? a : e;
			v = w ? e : {8'h00, d == 3'h1 ? e[15:8] : e[7:0]};
			xfer(1'b0, off, 32'h0);
			check("decrement value", {16'h0, e}, q);
			xfer(1'b0, `BDU_OFS_FLAGS, 32'h0);
			check("decrement flags", bad ? {28'h0, fl} : {28'h0, fl[3:2], v == 0, w ? v[15] : v[7]}, q);
			xfer(1'b0, `BDU_OFS_IRQ_STAT, 32'h0);
			check("decrement refused", {31'h0, bad}, {31'h0, q[2]});
		end
		$display("test decrement done, mismatches %0d", err_count);
		for (int i = 0; i < 20; i++) begin
			q = rnd();
			{sg, w, fl} = {q[0], q[1], q[7:4]};
			dd = rnd() >> (rnd() % 24);
			b = 16'(rnd());
			if (i == 0) {w, b} = {1'b0, 16'hA500};
			if (i == 1) {sg, w, dd, b} = {2'b00, 32'h0000FFFF, 16'h7701};
			if (i == 2) {sg, w, dd, b} = {2'b10, 32'h0000FFF9, 16'h3302};
			if (i == 3) {sg, w, dd, b} = {2'b11, 32'hFFFFFFF9, 16'h0002};
			if (i == 4) {w, b} = {1'b1, 16'h0000};
			xfer(1'b1, `BDU_OFS_FLAGS, {28'h0, fl});
			xfer(1'b1, `BDU_OFS_ACC_LOWER, {16'h0, dd[15:0]});
			xfer(1'b1, `BDU_OFS_ACC_UPPER, {16'h0, dd[31:16]});
			xfer(1'b1, `BDU_OFS_ADDR_SECOND, {16'h0, b});
			xfer(1'b1, `BDU_OFS_IRQ_STAT, 32'h7);
			cmd(sg ? signed_quotient_op : unsigned_quotient_op, w, sel_acc_lo, sel_addr_second);
			if (i == 5) cmd(minus_one_op, 1'b0, sel_acc_lo, sel_acc_lo);
			n = 0;
			do begin
				xfer(1'b0, `BDU_OFS_STATUS, 32'h0);
				n++;
			end while (q[0] !== 1'b0 && n < 40);
			check("busy", 32'h0, {31'h0, q[0]});
			rf = div_ref(sg, w, dd, b);
			xfer(1'b0, `BDU_OFS_FLAGS, 32'h0);
			check("divide flags", {28'h0, rf[32], fl[2:0]}, q);
			if (!rf[32]) begin
				xfer(1'b0, `BDU_OFS_ACC_LOWER, 32'h0);
				check("quotient", {16'h0, w ? rf[31:16] : {rf[7:0], rf[23:16]}}, q);
				xfer(1'b0, `BDU_OFS_ACC_UPPER, 32'h0);
				check("remainder", {16'h0, w ? rf[15:0] : dd[31:16]}, q);
			end
			xfer(1'b0, `BDU_OFS_IRQ_STAT, 32'h0);
			check("divide events", {29'h0, i == 5, rf[32], 1'b1}, q);
		end
		$display("test divide done, mismatches %0d", err_count);
		xfer(1'b1, `BDU_OFS_IRQ_MASK, 32'h1);
		cmd(minus_one_op, 1'b0, sel_acc_lo, sel_acc_lo);
		irq_is(1'b1);
		xfer(1'b0, `BDU_OFS_IRQ_MASK, 32'h0);
		check("mask readback", 32'h1, q);
		xfer(1'b1, `BDU_OFS_IRQ_MASK, 32'h0);
		irq_is(1'b0);
		xfer(1'b1, `BDU_OFS_IRQ_MASK, 32'h1);
		irq_is(1'b1);
		xfer(1'b1, `BDU_OFS_IRQ_STAT, 32'h1);
		irq_is(1'b0);
		$display("test interrupt done, mismatches %0d", err_count);
		close_out();
	end
endmodule : tb_top
